// ### dma_end_pkg.sv
// shared constants and types for the dma end and halt controller
package dma_end_pkg;
    localparam int NUM_CH = 8;
    localparam int ADDR_W = 32;
    localparam int CNT_W = 24;
    localparam int CODE_W = 12;
    localparam logic [CNT_W-1:0] CNT_ZERO = 24'h000000;
    localparam logic [CNT_W-1:0] CNT_ONE = 24'h000001;
    localparam logic [ADDR_W-1:0] ADDR_ZERO = 32'h00000000;
    // on-chip peripheral space, checked by its top address bits
    localparam logic [2:0] PERIPH_TOP = 3'h7;
    localparam int PERIPH_MSB = 31;
    localparam int PERIPH_LSB = 29;
    localparam logic [CODE_W-1:0] CODE_NONE = 12'h000;
    localparam logic [CODE_W-1:0] CODE_ADDR_ERR = 12'h6C0;
    localparam logic [CODE_W-1:0] CODE_END [NUM_CH] = '{
        12'h640, 12'h660, 12'h680, 12'h6A0, 12'h780, 12'h7A0, 12'h7C0, 12'h7E0};

    typedef struct packed {
        logic channel_enable;
        logic end_irq_enable;
        logic request_detect_select;
        logic single_addr;
        logic src_inc;
        logic dst_inc;
        logic [2:0] size_bytes;
    } channel_control_reg_t;

    typedef struct packed {
        logic [ADDR_W-1:0] src;
        logic [ADDR_W-1:0] dst;
        logic [CNT_W-1:0] count;
    } channel_setup_t;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_BUS = 2'b01,
        ST_STOP = 2'b10
    } bus_state_t;
endpackage : dma_end_pkg

// ### dma_channel_end_and_halt_control.sv
// eight-channel dma end, halt and event-code logic
// ---------------------------------------------------------------
// Overview of operation
// R01: channel raises end interrupt when count exhausted and its enable is 1.
// R02: channels 0-3 end codes 640,660,680,6A0; channel 0 highest priority.
// R03: channels 4-7 end codes 780-7E0; address error 6C0, lowest.
// R04: nmi halt flag sets on any nmi input, active or not.
// R05: count keeps set value or remaining count after nmi halt.
// R06: after abort, addresses read back the next addresses to access.
// R07: clearing master enable stops only after current bus cycle.
// R08: channel runs only with master and channel enables both 1.
// R09: software loads addresses and count before setting channel enable.
// R10: software clears channel enable before changing channel registers.
// R11: software writes 0 to count after a normal end.
// R12: single address to peripheral space flags address error, halts all; code flags it only when source and destination both lie there.
// R13: falling-edge requester holds line high during setup.
// R14: detect select 1 to 0 cancels an accepted edge request.
// R15: software confirms no transfer before standby entry.
// R16: software never targets control registers of listed units.
// R17: transfer starts only if enables 1, end flag 0, halt flags 0.
// R18: address error suspends all channels and raises its request.
// R19: end request holds until end flag or end enable is cleared.
// ---------------------------------------------------------------
`timescale 1ns/1ps

module dma_channel_end_and_halt_control (
    input wire logic MCLK,
    input wire logic RST_N,
    input wire logic GLOBAL_RUN_ENABLE,
    input wire logic NMI_IN,
    input wire logic NMI_FLAG_CLR,
    input wire logic ADDR_ERR_FLAG_CLR,
    input wire dma_end_pkg::channel_control_reg_t CTRL [dma_end_pkg::NUM_CH],
    input wire logic [dma_end_pkg::NUM_CH-1:0] SETUP_WR,
    input wire dma_end_pkg::channel_setup_t SETUP_DATA,
    input wire logic [dma_end_pkg::NUM_CH-1:0] END_FLAG_CLR,
    input wire logic [dma_end_pkg::NUM_CH-1:0] EXT_TRANSFER_REQUEST_N,
    input wire logic BUS_DONE,
    output logic [dma_end_pkg::NUM_CH-1:0] TRANSFER_END_FLAG,
    output logic NMI_HALT_FLAG,
    output logic ADDRESS_ERROR_FLAG,
    output logic [dma_end_pkg::NUM_CH-1:0] CHANNEL_END_EVENT,
    output logic ADDRESS_ERROR_EVENT,
    output logic [dma_end_pkg::CODE_W-1:0] EVENT_CODE_REG,
    output logic BUS_REQ,
    output logic [2:0] BUS_CH,
    output logic [dma_end_pkg::ADDR_W-1:0] BUS_SRC,
    output logic [dma_end_pkg::ADDR_W-1:0] BUS_DST,
    output dma_end_pkg::channel_setup_t READBACK [dma_end_pkg::NUM_CH],
    output logic BUSY
);
    // ---------------------------------------------------------------
    // reset release
    // ---------------------------------------------------------------
    logic rst_a_ff;
    logic rst_b_ff;
    logic rst_n;

    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            rst_a_ff <= 1'b0;
            rst_b_ff <= 1'b0;
        end else begin
            rst_a_ff <= 1'b1;
            rst_b_ff <= rst_a_ff;
        end
    end
    assign rst_n = rst_b_ff;

    // ---------------------------------------------------------------
    // pin synchronisers: three stages, change once stages 2 and 3 agree
    // ---------------------------------------------------------------
    localparam int SYN_W = dma_end_pkg::NUM_CH + 1;
    logic [SYN_W-1:0] syn1_ff;
    logic [SYN_W-1:0] syn2_ff;
    logic [SYN_W-1:0] syn3_ff;
    logic [SYN_W-1:0] filt_ff;
    logic [SYN_W-1:0] nxt_filt;

    always_comb begin
        nxt_filt = filt_ff;
        for (int i = 0; i < SYN_W; i++) begin
            if (syn2_ff[i] == syn3_ff[i]) begin
                nxt_filt[i] = syn3_ff[i];
            end
        end
    end

    always_ff @(posedge MCLK or negedge rst_n) begin
        if (!rst_n) begin
            syn1_ff <= '1;
            syn2_ff <= '1;
            syn3_ff <= '1;
            filt_ff <= '1;
        end else begin
            syn1_ff <= {~NMI_IN, EXT_TRANSFER_REQUEST_N};
            syn2_ff <= syn1_ff;
            syn3_ff <= syn2_ff;
            filt_ff <= nxt_filt;
        end
    end

    logic nmi_lvl;
    logic [dma_end_pkg::NUM_CH-1:0] req_lvl_n;
    logic nmi_prev_ff;
    logic [dma_end_pkg::NUM_CH-1:0] req_prev_n_ff;
    assign nmi_lvl = ~filt_ff[dma_end_pkg::NUM_CH];
    assign req_lvl_n = filt_ff[dma_end_pkg::NUM_CH-1:0];

    // ---------------------------------------------------------------
    // helpers
    // ---------------------------------------------------------------
    function automatic logic in_periph(input logic [dma_end_pkg::ADDR_W-1:0] a);
        in_periph = (a[dma_end_pkg::PERIPH_MSB:dma_end_pkg::PERIPH_LSB]
                     == dma_end_pkg::PERIPH_TOP);
    endfunction : in_periph

    function automatic logic [dma_end_pkg::ADDR_W-1:0] step(
        input logic [dma_end_pkg::ADDR_W-1:0] a, input logic inc, input logic [2:0] sz);
        step = inc ? a + {{(dma_end_pkg::ADDR_W-3){1'b0}}, sz} : a;
    endfunction : step

    // ---------------------------------------------------------------
    // channel and global state
    // ---------------------------------------------------------------
    dma_end_pkg::channel_setup_t ch_ff [dma_end_pkg::NUM_CH];
    dma_end_pkg::channel_setup_t nxt_ch [dma_end_pkg::NUM_CH];
    logic [dma_end_pkg::NUM_CH-1:0] end_ff;
    logic [dma_end_pkg::NUM_CH-1:0] nxt_end;
    logic [dma_end_pkg::NUM_CH-1:0] pend_ff;
    logic [dma_end_pkg::NUM_CH-1:0] nxt_pend;
    logic nmi_flag_ff;
    logic nxt_nmi_flag;
    logic ae_flag_ff;
    logic nxt_ae_flag;
    dma_end_pkg::bus_state_t state_ff;
    dma_end_pkg::bus_state_t nxt_state;
    logic [2:0] cur_ff;
    logic [2:0] nxt_cur;
    logic [dma_end_pkg::CODE_W-1:0] code_ff;
    logic [dma_end_pkg::CODE_W-1:0] nxt_code;

    logic [dma_end_pkg::NUM_CH-1:0] ready;
    logic halted;
    logic any_ready;
    logic [2:0] pick;
    logic cur_bad;

    always_comb begin
        halted = nmi_flag_ff | ae_flag_ff | ~GLOBAL_RUN_ENABLE;
        for (int i = 0; i < dma_end_pkg::NUM_CH; i++) begin
            ready[i] = CTRL[i].channel_enable & GLOBAL_RUN_ENABLE & ~end_ff[i] // [R08]
                       & ~nmi_flag_ff & ~ae_flag_ff & pend_ff[i]; // [R17]
        end
        any_ready = |ready;
        pick = 3'h0;
        for (int i = dma_end_pkg::NUM_CH - 1; i >= 0; i--) begin
            if (ready[i]) begin
                pick = 3'(i);
            end
        end
        cur_bad = CTRL[cur_ff].single_addr
                  & in_periph(ch_ff[cur_ff].src) & in_periph(ch_ff[cur_ff].dst); // [R12]
    end

    always_comb begin
        nxt_ch = ch_ff;
        nxt_end = end_ff;
        nxt_pend = pend_ff;
        nxt_state = state_ff;
        nxt_cur = cur_ff;
        nxt_nmi_flag = nmi_flag_ff;
        nxt_ae_flag = ae_flag_ff;
        nxt_code = dma_end_pkg::CODE_NONE;
        // flags: set wins over clear
        if (NMI_FLAG_CLR) begin
            nxt_nmi_flag = 1'b0;
        end
        if (nmi_lvl & ~nmi_prev_ff) begin
            nxt_nmi_flag = 1'b1; // [R04]
        end
        if (ADDR_ERR_FLAG_CLR) begin
            nxt_ae_flag = 1'b0;
        end
        for (int i = 0; i < dma_end_pkg::NUM_CH; i++) begin
            if (END_FLAG_CLR[i]) begin
                nxt_end[i] = 1'b0;
            end
            if (SETUP_WR[i] & ~CTRL[i].channel_enable) begin
                nxt_ch[i] = SETUP_DATA;
            end
            // edge-detected request is latched; detect select low makes it follow the request line level
            if (!CTRL[i].request_detect_select) begin
                nxt_pend[i] = ~req_lvl_n[i]; // [R14]
            end else if (~req_lvl_n[i] & req_prev_n_ff[i]) begin
                nxt_pend[i] = 1'b1;
            end
        end
        unique case (state_ff)
            dma_end_pkg::ST_IDLE: begin
                if (any_ready) begin
                    nxt_cur = pick;
                    nxt_state = dma_end_pkg::ST_BUS;
                end
            end
            dma_end_pkg::ST_BUS: begin
                if (cur_bad) begin
                    nxt_ae_flag = 1'b1; // [R12] [R18]
                    nxt_state = dma_end_pkg::ST_STOP;
                end else if (BUS_DONE) begin
                    // finish the cycle in flight, then look at halts
                    nxt_ch[cur_ff].src = step(ch_ff[cur_ff].src, CTRL[cur_ff].src_inc,
                                              CTRL[cur_ff].size_bytes); // [R06]
                    nxt_ch[cur_ff].dst = step(ch_ff[cur_ff].dst, CTRL[cur_ff].dst_inc,
                                              CTRL[cur_ff].size_bytes); // [R06]
                    nxt_ch[cur_ff].count = ch_ff[cur_ff].count - dma_end_pkg::CNT_ONE; // [R05]
                    if (CTRL[cur_ff].request_detect_select) begin
                        nxt_pend[cur_ff] = 1'b0;
                    end
                    if (ch_ff[cur_ff].count == dma_end_pkg::CNT_ONE) begin
                        nxt_end[cur_ff] = 1'b1; // [R01]
                    end
                    nxt_state = dma_end_pkg::ST_IDLE; // [R07]
                end
            end
            dma_end_pkg::ST_STOP: begin
                if (!halted) begin
                    nxt_state = dma_end_pkg::ST_IDLE;
                end
            end
            default: begin
                nxt_state = dma_end_pkg::ST_IDLE;
            end
        endcase
        // event code: channel 0 highest, address error lowest
        if (ae_flag_ff) begin
            nxt_code = dma_end_pkg::CODE_ADDR_ERR; // [R03]
        end
        for (int i = dma_end_pkg::NUM_CH - 1; i >= 0; i--) begin
            if (end_ff[i] & CTRL[i].end_irq_enable) begin
                nxt_code = dma_end_pkg::CODE_END[i]; // [R02] [R03]
            end
        end
    end

    always_ff @(posedge MCLK or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < dma_end_pkg::NUM_CH; i++) begin
                ch_ff[i] <= '{dma_end_pkg::ADDR_ZERO, dma_end_pkg::ADDR_ZERO,
                              dma_end_pkg::CNT_ZERO};
            end
            end_ff <= '0;
            pend_ff <= '0;
            nmi_flag_ff <= 1'b0;
            ae_flag_ff <= 1'b0;
            state_ff <= dma_end_pkg::ST_IDLE;
            cur_ff <= 3'h0;
            code_ff <= dma_end_pkg::CODE_NONE;
            nmi_prev_ff <= 1'b0;
            req_prev_n_ff <= '1;
        end else begin
            ch_ff <= nxt_ch;
            end_ff <= nxt_end;
            pend_ff <= nxt_pend;
            nmi_flag_ff <= nxt_nmi_flag;
            ae_flag_ff <= nxt_ae_flag;
            state_ff <= nxt_state;
            cur_ff <= nxt_cur;
            code_ff <= nxt_code;
            nmi_prev_ff <= nmi_lvl;
            req_prev_n_ff <= req_lvl_n;
        end
    end

    // ---------------------------------------------------------------
    // outputs
    // ---------------------------------------------------------------
    always_comb begin
        for (int i = 0; i < dma_end_pkg::NUM_CH; i++) begin
            CHANNEL_END_EVENT[i] = end_ff[i] & CTRL[i].end_irq_enable; // [R01] [R19]
            READBACK[i] = ch_ff[i]; // [R05] [R06]
        end
    end
    assign TRANSFER_END_FLAG = end_ff;
    assign NMI_HALT_FLAG = nmi_flag_ff;
    assign ADDRESS_ERROR_FLAG = ae_flag_ff;
    assign ADDRESS_ERROR_EVENT = ae_flag_ff; // [R18]
    assign EVENT_CODE_REG = code_ff;
    assign BUS_REQ = (state_ff == dma_end_pkg::ST_BUS) & ~cur_bad;
    assign BUS_CH = cur_ff;
    assign BUS_SRC = ch_ff[cur_ff].src;
    assign BUS_DST = ch_ff[cur_ff].dst;
    assign BUSY = (state_ff == dma_end_pkg::ST_BUS);
endmodule : dma_channel_end_and_halt_control

// ### dma_channel_end_and_halt_control_sva.sv
// port-level checker for the dma end and halt controller
`timescale 1ns/1ps

module dma_end_halt_checker (
    input wire logic MCLK,
    input wire logic RST_N,
    input wire logic GLOBAL_RUN_ENABLE,
    input wire logic NMI_IN,
    input wire dma_end_pkg::channel_control_reg_t CTRL [dma_end_pkg::NUM_CH],
    input wire logic BUS_DONE,
    input wire logic [dma_end_pkg::NUM_CH-1:0] TRANSFER_END_FLAG,
    input wire logic NMI_HALT_FLAG,
    input wire logic ADDRESS_ERROR_FLAG,
    input wire logic [dma_end_pkg::NUM_CH-1:0] CHANNEL_END_EVENT,
    input wire logic ADDRESS_ERROR_EVENT,
    input wire logic [dma_end_pkg::CODE_W-1:0] EVENT_CODE_REG,
    input wire logic BUS_REQ,
    input wire logic [2:0] BUS_CH,
    input wire logic [dma_end_pkg::ADDR_W-1:0] BUS_SRC,
    input wire logic [dma_end_pkg::ADDR_W-1:0] BUS_DST,
    input wire dma_end_pkg::channel_setup_t READBACK [dma_end_pkg::NUM_CH],
    input wire logic BUSY
);
    logic halt;
    default clocking cb @(posedge MCLK);
    endclocking
    default disable iff (!RST_N);
    assign halt = NMI_HALT_FLAG || ADDRESS_ERROR_FLAG || !GLOBAL_RUN_ENABLE;
    AST_END_EVT: assert property (CHANNEL_END_EVENT[0] == (TRANSFER_END_FLAG[0] && CTRL[0].end_irq_enable))
        else $error("end event mismatch");
    AST_AE_EVT: assert property (ADDRESS_ERROR_EVENT == ADDRESS_ERROR_FLAG)
        else $error("address error event mismatch");
    AST_CODE_CH0: assert property (CHANNEL_END_EVENT[0] |=> EVENT_CODE_REG == dma_end_pkg::CODE_END[0])
        else $error("channel 0 code wrong");
    AST_CODE_AE: assert property (ADDRESS_ERROR_EVENT && CHANNEL_END_EVENT == 8'h00
        |=> EVENT_CODE_REG == dma_end_pkg::CODE_ADDR_ERR) else $error("address error code wrong");
    AST_NO_START: assert property (halt ##1 (halt && !BUS_REQ) |=> !BUS_REQ)
        else $error("bus cycle started while halted");
    AST_REQ_HOLD: assert property (BUS_REQ && !BUS_DONE |=> BUS_REQ || ADDRESS_ERROR_FLAG)
        else $error("bus cycle dropped early");
    AST_COUNT_STEP: assert property (BUS_REQ && BUS_DONE && BUS_CH == 3'h0
        |=> READBACK[0].count == $past(READBACK[0].count) - 24'h000001) else $error("count step wrong");
    AST_END_SET: assert property (BUS_REQ && BUS_DONE && BUS_CH == 3'h0 && READBACK[0].count == 24'h000001
        |=> TRANSFER_END_FLAG[0]) else $error("end flag not set");
    AST_NMI_SET: assert property ($rose(NMI_IN) |-> ##[1:6] NMI_HALT_FLAG)
        else $error("nmi flag not set");
    AST_ADDR_STEP: assert property (BUS_REQ && BUS_DONE && BUS_CH == 3'h0
        && CTRL[0].src_inc && CTRL[0].dst_inc
        |=> READBACK[0].src == $past(BUS_SRC) + 32'($past(CTRL[0].size_bytes))
        && READBACK[0].dst == $past(BUS_DST) + 32'($past(CTRL[0].size_bytes)))
        else $error("address step wrong");
    AST_AE_STOP: assert property (BUSY && !BUS_REQ |=> ADDRESS_ERROR_FLAG && !BUSY)
        else $error("bad address did not stop the engine");
endmodule : dma_end_halt_checker

// ### bus_target_model.sv
// bus target that ends each requested bus cycle, promptly or slowly
`timescale 1ns/1ps

module bus_target_model (
    input wire logic clk,
    input wire logic bus_req,
    input wire logic slow,
    output logic bus_done
);
    int wait_cnt = 0;
    initial bus_done = 1'b0;
    always @(posedge clk) begin
        if (bus_req && !bus_done && wait_cnt >= (slow ? 12 : 1)) begin
            bus_done <= 1'b1;
            wait_cnt <= 0;
        end else begin
            bus_done <= 1'b0;
            wait_cnt <= (bus_req && !bus_done) ? wait_cnt + 1 : 0;
        end
    end
endmodule : bus_target_model

// ### test_dma_channel_end_and_halt_control.sv
// self-checking bench for the dma end and halt controller
`timescale 1ns/1ps

module test_dma_channel_end_and_halt_control;
    logic mclk = 1'b0;
    logic rst_n = 1'b0;
    logic run_en = 1'b0;
    logic nmi = 1'b0;
    logic nmi_clr = 1'b0;
    logic ae_clr = 1'b0;
    logic slow = 1'b0;
    logic bus_done, nmi_flag, ae_flag, bus_req, busy;
    dma_end_pkg::channel_control_reg_t ctrl [8];
    dma_end_pkg::channel_setup_t setup = '0;
    dma_end_pkg::channel_setup_t rb [8];
    logic [7:0] setup_wr = 8'h00;
    logic [7:0] end_clr = 8'h00;
    logic [7:0] req_n = 8'hFF;
    logic [7:0] end_flag;
    logic [11:0] code;
    logic [11:0] last_code = 12'h000;
    logic [11:0] exp_q [$];
    logic [10:0] flags;
    int seed = 76;
    int failures = 0;
    int checks = 0;
    assign flags = {bus_req, ae_flag, nmi_flag, end_flag};
    always #50 mclk = ~mclk;
    dma_channel_end_and_halt_control i_dut (.MCLK(mclk), .RST_N(rst_n),
        .GLOBAL_RUN_ENABLE(run_en), .NMI_IN(nmi), .NMI_FLAG_CLR(nmi_clr),
        .ADDR_ERR_FLAG_CLR(ae_clr), .CTRL(ctrl), .SETUP_WR(setup_wr), .SETUP_DATA(setup),
        .END_FLAG_CLR(end_clr), .EXT_TRANSFER_REQUEST_N(req_n), .BUS_DONE(bus_done),
        .TRANSFER_END_FLAG(end_flag), .NMI_HALT_FLAG(nmi_flag), .ADDRESS_ERROR_FLAG(ae_flag),
        .CHANNEL_END_EVENT(), .ADDRESS_ERROR_EVENT(), .EVENT_CODE_REG(code), .BUS_REQ(bus_req),
        .BUS_CH(), .BUS_SRC(), .BUS_DST(), .READBACK(rb), .BUSY(busy));
    bus_target_model i_target (.clk(mclk), .bus_req(bus_req), .slow(slow), .bus_done(bus_done));

    task final_report;
        if (failures == 0 && checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : final_report

    task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp) begin
            failures++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task wait_hi(input int i);
        int n;
        n = 0;
        while (flags[i] !== 1'b1 && n < 300) begin
            @(posedge mclk);
            n++;
        end
        if (flags[i] !== 1'b1) begin
            chk("wait", 32'h1, 32'h0);
            final_report();
        end
    endtask : wait_hi

    task load(input int ch, input logic [23:0] cnt, input logic [31:0] a, input logic ie);
        ctrl[ch] <= '0;
        @(posedge mclk);
        setup <= '{a, a ^ 32'h00001000, cnt};
        setup_wr <= 8'h01 << ch;
        @(posedge mclk);
        setup_wr <= 8'h00;
        ctrl[ch] <= '{1'b1, ie, 1'b0, a[31], 1'b1, 1'b1, 3'h4};
        @(posedge mclk);
    endtask : load

    task run(input int ch);
        logic [31:0] a;
        a = $random(seed) & 32'h1FFFFFFC;
        load(ch, 24'h000002, a, 1'b1);
        req_n[ch] <= 1'b0;
        wait_hi(ch);
        req_n[ch] <= 1'b1;
        chk("count", 32'h0, rb[ch].count);
        chk("src", a + 32'h8, rb[ch].src);
        chk("dst", (a ^ 32'h00001000) + 32'h8, rb[ch].dst);
    endtask : run

    always @(posedge mclk) begin
        if (rst_n && code !== last_code) begin
            last_code <= code;
            if (exp_q.size() == 0) begin
                chk("code", 32'hFFF, code);
            end else begin
                chk("code", exp_q.pop_front(), code);
            end
        end
    end

    initial begin
        for (int i = 0; i < 8; i++) ctrl[i] = '0;
        repeat (20) @(posedge mclk);
        rst_n <= 1'b1;
        repeat (8) @(posedge mclk);
        run_en <= 1'b1;
        for (int ch = 7; ch >= 0; ch--) begin
            exp_q.push_back(dma_end_pkg::CODE_END[ch]);
            run(ch);
        end
        for (int ch = 0; ch < 8; ch++) begin
            exp_q.push_back(ch < 7 ? dma_end_pkg::CODE_END[ch + 1] : dma_end_pkg::CODE_NONE);
            end_clr <= 8'h01 << ch;
            @(posedge mclk);
            end_clr <= 8'h00;
            repeat (3) @(posedge mclk);
        end
        run_en <= 1'b0;
        nmi <= 1'b1;
        wait_hi(8);
        nmi <= 1'b0;
        load(0, 24'h000003, 32'h00000100, 1'b0);
        run_en <= 1'b1;
        req_n[0] <= 1'b0;
        repeat (20) @(posedge mclk);
        chk("count", 32'h3, rb[0].count);
        slow <= 1'b1;
        nmi_clr <= 1'b1;
        @(posedge mclk);
        nmi_clr <= 1'b0;
        wait_hi(10);
        nmi <= 1'b1;
        repeat (30) @(posedge mclk);
        chk("count", 32'h2, rb[0].count);
        chk("end", 32'h0, end_flag[0]);
        nmi <= 1'b0;
        nmi_clr <= 1'b1;
        slow <= 1'b0;
        @(posedge mclk);
        nmi_clr <= 1'b0;
        wait_hi(0);
        req_n[0] <= 1'b1;
        load(1, 24'h000002, 32'hE0000000, 1'b1);
        exp_q.push_back(dma_end_pkg::CODE_ADDR_ERR);
        req_n[1] <= 1'b0;
        wait_hi(9);
        chk("count", 32'h2, rb[1].count);
        ctrl[1] <= '0;
        req_n[1] <= 1'b1;
        exp_q.push_back(dma_end_pkg::CODE_NONE);
        ae_clr <= 1'b1;
        @(posedge mclk);
        ae_clr <= 1'b0;
        repeat (6) @(posedge mclk);
        // edge-detected request: accept, cancel, then request again
        run_en <= 1'b0;
        load(2, 24'h000003, 32'h00000200, 1'b0);
        ctrl[2].request_detect_select <= 1'b1;
        repeat (2) @(posedge mclk);
        req_n[2] <= 1'b0;
        repeat (8) @(posedge mclk);
        req_n[2] <= 1'b1;
        repeat (6) @(posedge mclk);
        ctrl[2].request_detect_select <= 1'b0;
        repeat (2) @(posedge mclk);
        ctrl[2].request_detect_select <= 1'b1;
        run_en <= 1'b1;
        repeat (20) @(posedge mclk);
        chk("count", 32'h3, rb[2].count);
        req_n[2] <= 1'b0;
        repeat (30) @(posedge mclk);
        chk("count", 32'h2, rb[2].count);
        run_en <= 1'b0;
        repeat (4) @(posedge mclk);
        chk("busy", 32'h0, busy);
        chk("queue", 32'h0, exp_q.size());
        final_report();
    end
endmodule : test_dma_channel_end_and_halt_control

bind dma_channel_end_and_halt_control dma_end_halt_checker i_chk (.MCLK(MCLK), .RST_N(RST_N),
    .GLOBAL_RUN_ENABLE(GLOBAL_RUN_ENABLE), .NMI_IN(NMI_IN), .CTRL(CTRL), .BUS_DONE(BUS_DONE),
    .TRANSFER_END_FLAG(TRANSFER_END_FLAG), .NMI_HALT_FLAG(NMI_HALT_FLAG),
    .ADDRESS_ERROR_FLAG(ADDRESS_ERROR_FLAG), .CHANNEL_END_EVENT(CHANNEL_END_EVENT),
    .ADDRESS_ERROR_EVENT(ADDRESS_ERROR_EVENT), .EVENT_CODE_REG(EVENT_CODE_REG),
    .BUS_REQ(BUS_REQ), .BUS_CH(BUS_CH), .BUS_SRC(BUS_SRC), .BUS_DST(BUS_DST),
    .READBACK(READBACK), .BUSY(BUSY));
